// ===== hdl/dfrm_pkg.sv
/*
 * Constants and types shared by the drive fault restart manager.
 * Assumes a 100 MHz core clock and a 32-bit AXI4-Lite register bus.
 */
package dfrm_pkg;

	//****************************************************************
	// Timing
	//****************************************************************
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned T_TICK_MS     = 1000;  // Countdown step
	localparam int unsigned T_SKIP_MS     = 1000;  // Arrow hold, skip
	localparam int unsigned T_CLR_MS      = 3000;  // Arrow hold, clear
	localparam int unsigned CYC_PER_MS    = 1000000 / CLK_PERIOD_NS;
	localparam int unsigned TICK_CYC      = T_TICK_MS * CYC_PER_MS;
	localparam int unsigned SKIP_CYC      = T_SKIP_MS * CYC_PER_MS;
	localparam int unsigned CLR_CYC       = T_CLR_MS * CYC_PER_MS;

	//****************************************************************
	// Fault codes
	//****************************************************************
	localparam int NFLT   = 8;
	localparam int CODE_W = 3;
	localparam logic [2:0] F_GND       = 3'h0;
	localparam logic [2:0] F_PRECHG    = 3'h1;
	localparam logic [2:0] F_HI_VIN    = 3'h2;
	localparam logic [2:0] F_LO_VIN    = 3'h3;
	localparam logic [2:0] F_AUX_LATCH = 3'h4;
	localparam logic [2:0] F_SUPPLY    = 3'h5;
	localparam logic [2:0] F_AUX_OUT   = 3'h6;
	localparam logic [2:0] F_AUX_OVL   = 3'h7;
	localparam logic [7:0] INIT_MASK    = 8'h0F;
	localparam logic [7:0] NORES_FORCED = 8'h50;
	localparam int LOG_DEPTH = 8;

	//****************************************************************
	// Register map and fields
	//****************************************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] A_CTRL     = 8'h00;
	localparam logic [7:0] A_STATUS   = 8'h04;
	localparam logic [7:0] A_NORES    = 8'h08;
	localparam logic [7:0] A_AUX_LIM  = 8'h0C;
	localparam logic [7:0] A_LOG_CNT  = 8'h10;
	localparam logic [7:0] A_CFG_BASE = 8'h20;
	localparam logic [7:0] A_CNT_BASE = 8'h40;
	localparam logic [7:0] A_LOG_BASE = 8'h60;
	localparam logic [7:0] A_END      = 8'h80;
	localparam int C_EN      = 0;
	localparam int C_CLR     = 1;
	localparam int C_AUXSEL  = 2;
	localparam int CFG_ALLOW = 0;
	localparam int CFG_DELAY = 8;
	localparam int S_CODE    = 0;
	localparam int S_STATE   = 8;
	localparam int S_AUTO    = 13;
	localparam int S_SECS    = 16;
	localparam logic [7:0]  NORES_RST   = 8'h51;
	localparam logic [7:0]  ALLOW_RST   = 8'h00;
	localparam logic [7:0]  DELAY_RST   = 8'h0A;
	localparam logic [15:0] AUX_LIM_RST = 16'hFFFF;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	//****************************************************************
	// Types
	//****************************************************************
	typedef enum logic [4:0] {
		ST_INIT  = 5'h01,
		ST_RUN   = 5'h02,
		ST_COUNT = 5'h04,
		ST_WAIT  = 5'h08,
		ST_NORES = 5'h10
	} dfrm_state_t;

	typedef struct packed {
		logic       fault_shown;
		logic       pending;
		logic       enter_prompt;
		logic       no_restart;
		logic [2:0] code;
		logic [7:0] secs;
	} dfrm_disp_t;

endpackage

// ===== hdl/dfrm_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes asynchronous pin levels and a synchronous-release reset.
 */
`timescale 1ns/1ps

module dfrm_sync #(
	parameter int W = 10
) (
	input  wire logic         i_core_clk,
	input  wire logic         i_rstn,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_level
);
	import dfrm_pkg::*;

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] lvl_r;
	logic [W-1:0] lvl_nxt;

	// Accept a new level once stages two and three agree
	always_comb begin
		lvl_nxt = lvl_r;
		for (int i = 0; i < W; i++) begin
			if (s2_r[i] == s3_r[i]) lvl_nxt[i] = s3_r[i];
		end
	end

	// Shift chain and filtered level
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s1_r  <= '0;
			s2_r  <= '0;
			s3_r  <= '0;
			lvl_r <= '0;
		end else begin
			s1_r  <= i_async;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	assign o_level = lvl_r;

endmodule

// ===== hdl/dfrm_top.sv
/*
 * Fault latch, restart supervisor, restart log and AXI4-Lite registers.
 * Assumes detector and keypad pins are asynchronous, aux current comes
 * from logic on the core clock, and a single 100 MHz core clock.
 */
`timescale 1ns/1ps
// Functional notes
// - Both arrows held one second during countdown restart load now.
// - Memory clear empties restart log and zeroes per-fault counters.
// - Non-restartable fault shows no-restart; cleared by 3 s arrows.
// - Each fault has a no-restart attribute that blocks auto restart.
// - Restart pending shown with remaining seconds, one per second.
// - Restart allowance and delay programmable per fault; allow = 0.
// - Budget gone or disabled: prompt enter; enter restarts, zeroes.
// - Restart enable gates auto restart (except supply overload) and auto mode at init exit; enter sets auto mode regardless; default off.
// - Init faults are shown, not logged; running waits for clear.
// - Same faults after init are logged and cleared normally.
// - Open aux latch contact latches fault, stops drive, no restart.
// - Terminal supply overload faults; clears after its own delay.
// - Aux output inverter high current faults with no restart.
// - Aux current above programmed limit raises overload fault.

module dfrm_top #(
	parameter int unsigned P_TICK_CYC = dfrm_pkg::TICK_CYC,
	parameter int unsigned P_SKIP_CYC = dfrm_pkg::SKIP_CYC,
	parameter int unsigned P_CLR_CYC  = dfrm_pkg::CLR_CYC
) (
	input  wire logic                        i_core_clk,
	input  wire logic                        i_rstn,
	input  wire logic                        i_awvalid,
	output logic                             o_awready,
	input  wire logic [dfrm_pkg::ADDR_W-1:0] i_awaddr,
	input  wire logic                        i_wvalid,
	output logic                             o_wready,
	input  wire logic [31:0]                 i_wdata,
	input  wire logic [3:0]                  i_wstrb,
	output logic                             o_bvalid,
	input  wire logic                        i_bready,
	output logic      [1:0]                  o_bresp,
	input  wire logic                        i_arvalid,
	output logic                             o_arready,
	input  wire logic [dfrm_pkg::ADDR_W-1:0] i_araddr,
	output logic                             o_rvalid,
	input  wire logic                        i_rready,
	output logic      [31:0]                 o_rdata,
	output logic      [1:0]                  o_rresp,
	input  wire logic [3:0]                  i_init_flt,
	input  wire logic                        i_supply_ovl,
	input  wire logic                        i_aux_out_flt,
	input  wire logic                        i_aux_contact,
	input  wire logic                        i_key_up,
	input  wire logic                        i_key_down,
	input  wire logic                        i_key_enter,
	input  wire logic [15:0]                 i_aux_current,
	output logic                             o_run,
	output logic                             o_auto_mode,
	output dfrm_pkg::dfrm_disp_t             o_disp
);
	import dfrm_pkg::*;

	//****************************************************************
	// Declarations
	//****************************************************************
	logic        rst_meta_r;
	logic        rst_n;
	logic [9:0]  pin_lvl;
	logic [7:0]  f_raw;
	logic [7:0]  nores_eff;
	logic [2:0]  sel_code;
	logic        both_arrows;
	logic        ent_rise;
	logic        skip_hit;
	logic        clr_hit;
	logic        tick_hit;
	logic        wr_do;
	logic        clr_mem;
	logic [31:0] rd_word;
	logic        rd_ok;
	logic [31:0] wv;
	// Bus and configuration state
	logic        awg_r, awg_nxt, wg_r, wg_nxt;
	logic [7:0]  awa_r, awa_nxt;
	logic [31:0] wd_r, wd_nxt;
	logic [3:0]  ws_r, ws_nxt;
	logic        bv_r, bv_nxt, rv_r, rv_nxt;
	logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic        en_r, en_nxt, auxsel_r, auxsel_nxt;
	logic [7:0]  nores_r, nores_nxt;
	logic [15:0] aux_lim_r, aux_lim_nxt;
	logic [7:0]  allow_r [NFLT];
	logic [7:0]  allow_nxt [NFLT];
	logic [7:0]  delay_r [NFLT];
	logic [7:0]  delay_nxt [NFLT];
	// Supervisor state
	dfrm_state_t st_r, st_nxt;
	logic [2:0]  code_r, code_nxt;
	logic [7:0]  secs_r, secs_nxt;
	logic        auto_r, auto_nxt, run_r, ent_prev_r;
	logic [31:0] tick_r, tick_nxt, hold_r, hold_nxt;
	logic [7:0]  cnt_r [NFLT];
	logic [7:0]  cnt_nxt [NFLT];
	logic [2:0]  log_r [LOG_DEPTH];
	logic [2:0]  log_nxt [LOG_DEPTH];
	logic [3:0]  lcnt_r, lcnt_nxt;
	logic [2:0]  settle_r, settle_nxt;
	dfrm_disp_t  disp_r, disp_nxt;

	// Lowest set bit as a fault code
	function automatic logic [CODE_W-1:0] first_set(
		input logic [NFLT-1:0] v);
		first_set = '0;
		for (int i = NFLT - 1; i >= 0; i--) begin
			if (v[i]) first_set = CODE_W'(i);
		end
	endfunction

	// Byte-lane merge of a write into an old word
	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		wmerge = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) wmerge[b*8 +: 8] = nw[b*8 +: 8];
		end
	endfunction

	// Address lands on an implemented register
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a < A_CFG_BASE) ? (a <= A_LOG_CNT + 8'h03) : (a < A_END);
	endfunction

	//****************************************************************
	// Reset release and input conditioning
	//****************************************************************
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	dfrm_sync #(.W(10)) u_sync (
		.i_core_clk (i_core_clk),
		.i_rstn     (rst_n),
		.i_async    ({i_key_enter, i_key_down, i_key_up, i_aux_contact,
		              i_aux_out_flt, i_supply_ovl, i_init_flt}),
		.o_level    (pin_lvl)
	);

	// Fault vector, non-restartable faults picked first
	assign f_raw = {i_aux_current > aux_lim_r,
	                pin_lvl[5],
	                pin_lvl[4],
	                auxsel_r & ~pin_lvl[6],
	                pin_lvl[3:0]};
	assign nores_eff   = nores_r | NORES_FORCED;
	assign sel_code    = first_set((|(f_raw & nores_eff)) ?
	                     (f_raw & nores_eff) : f_raw);
	assign both_arrows = pin_lvl[7] & pin_lvl[8];
	assign ent_rise    = pin_lvl[9] & ~ent_prev_r;
	assign skip_hit    = both_arrows && hold_r == P_SKIP_CYC - 1;
	assign clr_hit     = both_arrows && hold_r == P_CLR_CYC - 1;
	assign tick_hit    = tick_r == P_TICK_CYC - 1;

	//****************************************************************
	// AXI4-Lite slave and configuration registers
	//****************************************************************
	assign o_awready = !awg_r && !bv_r;
	assign o_wready  = !wg_r && !bv_r;
	assign o_arready = !rv_r;
	assign wr_do     = awg_r && wg_r && !bv_r;

	// Read decode
	always_comb begin
		rd_word = 32'h0;
		rd_ok   = mapped(i_araddr);
		if (i_araddr >= A_LOG_BASE) begin
			rd_word[2:0] = log_r[i_araddr[4:2]];
		end else if (i_araddr >= A_CNT_BASE) begin
			rd_word[7:0] = cnt_r[i_araddr[4:2]];
		end else if (i_araddr >= A_CFG_BASE) begin
			rd_word[CFG_ALLOW +: 8] = allow_r[i_araddr[4:2]];
			rd_word[CFG_DELAY +: 8] = delay_r[i_araddr[4:2]];
		end else begin
			case (i_araddr[7:2])
			A_CTRL[7:2]: begin
				rd_word[C_EN]     = en_r;
				rd_word[C_AUXSEL] = auxsel_r;
			end
			A_STATUS[7:2]: begin
				rd_word[S_CODE +: 3]  = code_r;
				rd_word[S_STATE +: 5] = st_r;
				rd_word[S_AUTO]       = auto_r;
				rd_word[S_SECS +: 8]  = secs_r;
			end
			A_NORES[7:2]:   rd_word[7:0] = nores_eff;
			A_AUX_LIM[7:2]: rd_word[15:0] = aux_lim_r;
			A_LOG_CNT[7:2]: rd_word[3:0] = lcnt_r;
			default:        rd_word = 32'h0;
			endcase
		end
	end

	// Channel handshakes and register writes
	always_comb begin
		awg_nxt = awg_r; awa_nxt = awa_r; wg_nxt = wg_r;
		wd_nxt = wd_r; ws_nxt = ws_r; bv_nxt = bv_r; br_nxt = br_r;
		rv_nxt = rv_r; rr_nxt = rr_r; rd_nxt = rd_r;
		en_nxt = en_r; auxsel_nxt = auxsel_r; nores_nxt = nores_r;
		aux_lim_nxt = aux_lim_r; allow_nxt = allow_r; delay_nxt = delay_r;
		clr_mem = 1'b0;
		wv = 32'h0;
		if (o_awready && i_awvalid) begin
			awg_nxt = 1'b1;
			awa_nxt = i_awaddr;
		end
		if (o_wready && i_wvalid) begin
			wg_nxt = 1'b1;
			wd_nxt = i_wdata;
			ws_nxt = i_wstrb;
		end
		if (bv_r && i_bready) bv_nxt = 1'b0;
		if (wr_do) begin
			awg_nxt = 1'b0;
			wg_nxt  = 1'b0;
			bv_nxt  = 1'b1;
			br_nxt  = mapped(awa_r) ? RESP_OKAY : RESP_SLVERR;
			if (awa_r >= A_CFG_BASE && awa_r < A_CNT_BASE) begin
				wv = wmerge({16'h0, delay_r[awa_r[4:2]],
				             allow_r[awa_r[4:2]]}, wd_r, ws_r);
				allow_nxt[awa_r[4:2]] = wv[CFG_ALLOW +: 8];
				delay_nxt[awa_r[4:2]] = wv[CFG_DELAY +: 8];
			end else if (awa_r[7:2] == A_CTRL[7:2]) begin
				wv = wmerge({29'h0, auxsel_r, 1'b0, en_r}, wd_r, ws_r);
				en_nxt     = wv[C_EN];
				auxsel_nxt = wv[C_AUXSEL];
				clr_mem    = wv[C_CLR];
			end else if (awa_r[7:2] == A_NORES[7:2]) begin
				wv = wmerge({24'h0, nores_r}, wd_r, ws_r);
				nores_nxt = wv[7:0];
			end else if (awa_r[7:2] == A_AUX_LIM[7:2]) begin
				wv = wmerge({16'h0, aux_lim_r}, wd_r, ws_r);
				aux_lim_nxt = wv[15:0];
			end
		end
		if (rv_r && i_rready) rv_nxt = 1'b0;
		if (o_arready && i_arvalid) begin
			rv_nxt = 1'b1;
			rd_nxt = rd_word;
			rr_nxt = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// Bus and configuration flops
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			awg_r <= 1'b0; awa_r <= 8'h00; wg_r <= 1'b0;
			wd_r <= 32'h0; ws_r <= 4'h0; bv_r <= 1'b0; br_r <= 2'h0;
			rv_r <= 1'b0; rr_r <= 2'h0; rd_r <= 32'h0;
			en_r      <= 1'b0;
			auxsel_r  <= 1'b0;
			nores_r   <= NORES_RST;
			aux_lim_r <= AUX_LIM_RST;
			for (int i = 0; i < NFLT; i++) begin
				allow_r[i] <= ALLOW_RST;
				delay_r[i] <= DELAY_RST;
			end
		end else begin
			awg_r <= awg_nxt; awa_r <= awa_nxt; wg_r <= wg_nxt;
			wd_r <= wd_nxt; ws_r <= ws_nxt; bv_r <= bv_nxt; br_r <= br_nxt;
			rv_r <= rv_nxt; rr_r <= rr_nxt; rd_r <= rd_nxt;
			en_r <= en_nxt; auxsel_r <= auxsel_nxt; nores_r <= nores_nxt;
			aux_lim_r <= aux_lim_nxt;
			allow_r <= allow_nxt;
			delay_r <= delay_nxt;
		end
	end

	assign o_bvalid = bv_r;
	assign o_bresp  = br_r;
	assign o_rvalid = rv_r;
	assign o_rresp  = rr_r;
	assign o_rdata  = rd_r;

	//****************************************************************
	// Restart supervisor
	//****************************************************************
	always_comb begin
		st_nxt = st_r; code_nxt = code_r; secs_nxt = secs_r;
		auto_nxt = auto_r; cnt_nxt = cnt_r; log_nxt = log_r;
		lcnt_nxt = lcnt_r;
		// Pin filter levels are only valid a few cycles after reset
		settle_nxt = (&settle_r) ? settle_r : settle_r + 3'h1;
		tick_nxt = (st_r == ST_COUNT && !tick_hit) ? tick_r + 32'h1 : 32'h0;
		hold_nxt = 32'h0;
		if (both_arrows) hold_nxt = (hold_r == P_CLR_CYC) ? hold_r : hold_r + 32'h1;
		case (st_r)
		ST_INIT: begin
			if (|(f_raw & INIT_MASK)) begin
				code_nxt = first_set(f_raw & INIT_MASK);
			end else if (&settle_r) begin
				st_nxt   = ST_RUN;
				auto_nxt = en_r;
			end
		end
		ST_RUN: begin
			if (!auto_r && ent_rise) auto_nxt = 1'b1;
			if (|f_raw) begin
				code_nxt = sel_code;
				if (lcnt_r < 4'(LOG_DEPTH)) begin
					log_nxt[lcnt_r[2:0]] = sel_code;
					lcnt_nxt = lcnt_r + 4'h1;
				end
				if (nores_eff[sel_code]) begin
					st_nxt = ST_NORES;
				end else if (sel_code == F_SUPPLY ||
				             (en_r && cnt_r[sel_code] < allow_r[sel_code])) begin
					st_nxt   = ST_COUNT;
					secs_nxt = delay_r[sel_code];
				end else begin
					st_nxt = ST_WAIT;
				end
			end
		end
		ST_COUNT: begin
			if (skip_hit || (secs_r == 8'h00 && !f_raw[code_r])) begin
				st_nxt   = ST_RUN;
				auto_nxt = 1'b1;
				if (code_r != F_SUPPLY) begin
					cnt_nxt[code_r] = cnt_r[code_r] + 8'h01;
				end
			end else if (tick_hit && secs_r != 8'h00) begin
				secs_nxt = secs_r - 8'h01;
			end
		end
		ST_WAIT: begin
			if (ent_rise) begin
				st_nxt   = ST_RUN;
				auto_nxt = 1'b1;
				for (int i = 0; i < NFLT; i++) cnt_nxt[i] = 8'h00;
			end
		end
		ST_NORES: begin
			if (clr_hit) begin
				st_nxt   = ST_RUN;
				auto_nxt = 1'b0;
			end
		end
		default: st_nxt = ST_INIT;
		endcase
		if (clr_mem) begin
			lcnt_nxt = 4'h0;
			for (int i = 0; i < NFLT; i++) cnt_nxt[i] = 8'h00;
		end
		disp_nxt.fault_shown  = (st_nxt != ST_RUN);
		disp_nxt.pending      = (st_nxt == ST_COUNT);
		disp_nxt.enter_prompt = (st_nxt == ST_WAIT);
		disp_nxt.no_restart   = (st_nxt == ST_NORES);
		disp_nxt.code         = code_nxt;
		disp_nxt.secs         = secs_nxt;
	end

	// Supervisor flops
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= ST_INIT; code_r <= 3'h0; secs_r <= 8'h00;
			auto_r <= 1'b0; run_r <= 1'b0; ent_prev_r <= 1'b0;
			tick_r <= 32'h0; hold_r <= 32'h0; lcnt_r <= 4'h0;
			settle_r <= 3'h0;
			disp_r <= '0;
			for (int i = 0; i < NFLT; i++) cnt_r[i] <= 8'h00;
			for (int i = 0; i < LOG_DEPTH; i++) log_r[i] <= 3'h0;
		end else begin
			st_r <= st_nxt; code_r <= code_nxt; secs_r <= secs_nxt;
			auto_r <= auto_nxt; ent_prev_r <= pin_lvl[9];
			run_r  <= (st_nxt == ST_RUN) && auto_nxt;
			tick_r <= tick_nxt; hold_r <= hold_nxt; lcnt_r <= lcnt_nxt;
			settle_r <= settle_nxt;
			disp_r <= disp_nxt;
			cnt_r  <= cnt_nxt;
			log_r  <= log_nxt;
		end
	end

	assign o_run       = run_r;
	assign o_auto_mode = auto_r;
	assign o_disp      = disp_r;

	//****************************************************************
	// Assertions
	//****************************************************************
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!rst_n);

	a_skip_starts:
	assert property ((st_r == ST_COUNT && skip_hit) |=> (st_r == ST_RUN && o_run))
	else $error("arrow skip did not start load");
	a_mem_clear:
	assert property (clr_mem |=> (lcnt_r == 4'h0 && cnt_r[code_r] == 8'h00))
	else $error("memory clear left log or counter");
	a_nores_holds:
	assert property ((st_r == ST_NORES && !clr_hit)
		|=> (st_r == ST_NORES && o_disp.no_restart))
	else $error("no-restart fault left without clear hold");
	a_secs_step:
	assert property ((st_r == ST_COUNT && tick_hit && secs_r != 8'h00 && !skip_hit)
		|=> secs_r == $past(secs_r) - 8'h01)
	else $error("countdown did not step by one");
	a_enter_clears:
	assert property ((st_r == ST_WAIT && ent_rise) |=> (o_run && cnt_r[code_r] == 8'h00))
	else $error("enter did not restart and clear");
	a_enable_gate:
	assert property ((st_r == ST_RUN && |f_raw && !en_r && sel_code != F_SUPPLY)
		|=> st_r != ST_COUNT)
	else $error("countdown began with restart disabled");
	a_init_unlogged:
	assert property ((st_r == ST_INIT && !clr_mem) |-> (!o_run ##1 $stable(lcnt_r)))
	else $error("init fault logged or load run");
	a_aux_latch:
	assert property ((st_r == ST_RUN && f_raw[F_AUX_LATCH]) |=> (st_r == ST_NORES && !o_run))
	else $error("aux latch fault did not stop drive");
	a_aux_overload:
	assert property ((st_r == ST_RUN && i_aux_current > aux_lim_r) |=> st_r != ST_RUN)
	else $error("aux overload not raised");
	a_budget_spent:
	assert property ((st_r == ST_RUN && |f_raw && !nores_eff[sel_code] && sel_code != F_SUPPLY
		&& cnt_r[sel_code] >= allow_r[sel_code]) |=> st_r == ST_WAIT)
	else $error("restart past allowance");

endmodule

// ===== sim/dfrm_panel.sv
/*
 * Model of the keypad and the fault detectors around the restart manager.
 * Assumes the bench calls its tasks just after a rising core clock edge.
 */
`timescale 1ns/1ps

module dfrm_panel (
	input  wire logic        i_core_clk,
	output logic      [3:0]  o_init_flt,
	output logic             o_aux_contact,
	output logic             o_supply_ovl,
	output logic             o_aux_out_flt,
	output logic             o_key_up,
	output logic             o_key_down,
	output logic             o_key_enter,
	output logic      [15:0] o_aux_current
);
	//****************************************************************
	// Detector levels
	//****************************************************************
	logic [6:0] flt_r;

	// Bit 4 is an open contact, so the pin itself is inverted
	assign o_init_flt    = flt_r[3:0];
	assign o_aux_contact = !flt_r[4];
	assign o_supply_ovl  = flt_r[5];
	assign o_aux_out_flt = flt_r[6];

	// Idle: no faults, keys up, contact closed
	initial begin
		flt_r = 7'h00;
		o_key_up = 1'b0;
		o_key_down = 1'b0;
		o_key_enter = 1'b0;
		o_aux_current = 16'h0000;
	end

	// One detector line to a level
	task pin_set(input int k, input logic v);
		flt_r[k] <= v;
	endtask

	// Aux current value from the measuring logic
	task current(input logic [15:0] v);
		o_aux_current <= v;
	endtask

	// Both arrows held for n cycles, then let go
	task arrows(input int n);
		o_key_up <= 1'b1;
		o_key_down <= 1'b1;
		repeat (n) @(posedge i_core_clk);
		o_key_up <= 1'b0;
		o_key_down <= 1'b0;
		repeat (6) @(posedge i_core_clk);
	endtask

	// Enter pressed long enough to pass the pin filter
	task enter();
		o_key_enter <= 1'b1;
		repeat (6) @(posedge i_core_clk);
		o_key_enter <= 1'b0;
		repeat (6) @(posedge i_core_clk);
	endtask
endmodule

// ===== sim/dfrm_top_tb_top.sv
/*
 * Self-checking bench for the restart manager, registers over AXI4-Lite.
 * Assumes short tick, skip and clear counts set by parameter.
 */
`timescale 1ns/1ps

module dfrm_top_tb_top;
	import dfrm_pkg::*;
	localparam int unsigned TK = 20;
	localparam int unsigned SK = 8;
	localparam int unsigned CL = 24;
	logic i_core_clk, i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid;
	logic i_rready, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic o_run, o_auto_mode, i_supply_ovl, i_aux_out_flt, i_aux_contact;
	logic i_key_up, i_key_down, i_key_enter;
	logic [7:0] i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata, rd;
	logic [3:0] i_wstrb, i_init_flt;
	logic [1:0] o_bresp, o_rresp, rr;
	logic [15:0] i_aux_current;
	dfrm_disp_t o_disp;
	int error_cnt, total_checks, n;

	dfrm_top #(.P_TICK_CYC(TK), .P_SKIP_CYC(SK), .P_CLR_CYC(CL)) dut (.*);
	dfrm_panel panel (.i_core_clk(i_core_clk), .o_init_flt(i_init_flt),
		.o_aux_contact(i_aux_contact), .o_supply_ovl(i_supply_ovl),
		.o_aux_out_flt(i_aux_out_flt), .o_key_up(i_key_up),
		.o_key_down(i_key_down), .o_key_enter(i_key_enter),
		.o_aux_current(i_aux_current));

	//****************************************************************
	// Bus and check tasks
	//****************************************************************
	// Verdict and end of run
	task results();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Compare seen against expected
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// AXI4-Lite write, address and data offered together
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_d, w_d, b_d;
		int k;
		aw_d = 0;
		w_d = 0;
		b_d = 0;
		i_awaddr <= a;
		i_wdata <= d;
		i_wstrb <= 4'hF;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		for (k = 0; k < 50 && !b_d; k++) begin
			@(posedge i_core_clk);
			if (o_bvalid) begin
				b_d = 1;
				rr = o_bresp;
			end
			if (o_awready && !aw_d) begin
				aw_d = 1;
				i_awvalid <= 1'b0;
			end
			if (o_wready && !w_d) begin
				w_d = 1;
				i_wvalid <= 1'b0;
			end
		end
		i_bready <= 1'b0;
		if (!b_d) begin
			chk(32'h0, 32'h1);
			results();
		end
		@(posedge i_core_clk);
	endtask

	// AXI4-Lite read into rd and rr
	task rdr(input logic [7:0] a);
		logic a_d, r_d;
		int k;
		a_d = 0;
		r_d = 0;
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		for (k = 0; k < 50 && !r_d; k++) begin
			@(posedge i_core_clk);
			if (o_rvalid) begin
				r_d = 1;
				rd = o_rdata;
				rr = o_rresp;
			end
			if (o_arready && !a_d) begin
				a_d = 1;
				i_arvalid <= 1'b0;
			end
		end
		i_rready <= 1'b0;
		if (!r_d) begin
			chk(32'h0, 32'h1);
			results();
		end
		@(posedge i_core_clk);
	endtask

	// Masked register compare
	task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rdr(a);
		chk(rd & m, e);
	endtask

	// Poll the state field for at most b reads
	task wst(input logic [4:0] s, input int b);
		int k;
		for (k = 0; k < b; k++) begin
			rdr(A_STATUS);
			if (rd[12:8] === s) break;
		end
		chk({27'h0, rd[12:8]}, {27'h0, s});
	endtask

	//****************************************************************
	// Clock and main sequence
	//****************************************************************
	// 100 MHz core clock
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end

	// Scenarios in order, one shared state of the drive
	initial begin
		error_cnt = 0;
		total_checks = 0;
		{i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h00;
		{i_awaddr, i_araddr, i_wstrb, i_wdata} = 52'h0;
		panel.pin_set(0, 1'b1);
		repeat (10) @(posedge i_core_clk);
		i_rstn <= 1'b1;
		repeat (12) @(posedge i_core_clk);
		wst(ST_INIT, 1);
		chk(o_disp.fault_shown, 1'b1);
		panel.pin_set(0, 1'b0);
		wst(ST_RUN, 10);
		rc(A_LOG_CNT, 32'hF, 32'h0);
		chk(o_auto_mode, 1'b0);
		rc(A_CFG_BASE, 32'hFFFF, 32'h0A00);
		rdr(8'h14);
		chk(rr, RESP_SLVERR);
		wr(8'h14, 32'h0);
		chk(rr, RESP_SLVERR);
		wr(A_CTRL, 32'h0);
		chk(rr, RESP_OKAY);
		panel.enter();
		// Low input after init with restarts disabled
		panel.pin_set(3, 1'b1);
		wst(ST_WAIT, 10);
		panel.pin_set(3, 1'b0);
		chk(o_disp.enter_prompt, 1'b1);
		rc(A_LOG_CNT, 32'hF, 32'h1);
		panel.enter();
		wst(ST_RUN, 5);
		// Countdown of two seconds, one restart allowed
		wr(A_CTRL, 32'h1);
		wr(A_CFG_BASE + 8'h08, 32'h0201);
		panel.pin_set(2, 1'b1);
		wst(ST_COUNT, 10);
		panel.pin_set(2, 1'b0);
		chk(o_disp.pending, 1'b1);
		n = 0;
		while (o_disp.secs !== 8'h01 && n < 100) begin
			@(posedge i_core_clk);
			n++;
		end
		n = 0;
		do begin
			@(posedge i_core_clk);
			n++;
		end while (o_disp.secs === 8'h01 && n < 100);
		chk(n, TK);
		wst(ST_RUN, 20);
		rc(A_CNT_BASE + 8'h08, 32'hFF, 32'h1);
		panel.pin_set(2, 1'b1);
		wst(ST_WAIT, 10);
		panel.pin_set(2, 1'b0);
		panel.enter();
		rc(A_CNT_BASE + 8'h08, 32'hFF, 32'h0);
		// Long countdown cut short by both arrows
		wr(A_CFG_BASE + 8'h08, 32'h3201);
		panel.pin_set(2, 1'b1);
		wst(ST_COUNT, 10);
		panel.pin_set(2, 1'b0);
		panel.arrows(SK + 6);
		wst(ST_RUN, 3);
		rc(A_LOG_CNT, 32'hF, 32'h4);
		wr(A_CTRL, 32'h3);
		rc(A_LOG_CNT, 32'hF, 32'h0);
		rc(A_CNT_BASE + 8'h08, 32'hFF, 32'h0);
		// Faults that never restart on their own
		wr(A_NORES, 32'h0);
		rc(A_NORES, 32'hFF, 32'h50);
		panel.pin_set(6, 1'b1);
		wst(ST_NORES, 10);
		panel.pin_set(6, 1'b0);
		chk(o_disp.no_restart, 1'b1);
		panel.arrows(SK + 6);
		wst(ST_NORES, 1);
		panel.arrows(CL + 10);
		wst(ST_RUN, 3);
		chk(o_run, 1'b0);
		panel.enter();
		wr(A_CTRL, 32'h5);
		panel.pin_set(4, 1'b1);
		repeat (8) @(posedge i_core_clk);
		panel.pin_set(4, 1'b0);
		wst(ST_NORES, 10);
		chk(o_run, 1'b0);
		repeat (20) @(posedge i_core_clk);
		wst(ST_NORES, 1);
		panel.arrows(CL + 10);
		panel.enter();
		// Terminal supply overload clears after its delay
		panel.pin_set(5, 1'b1);
		wst(ST_COUNT, 10);
		panel.pin_set(5, 1'b0);
		wst(ST_RUN, 100);
		// Aux current against its limit
		wr(A_AUX_LIM, 32'h100);
		panel.current(16'h0100);
		repeat (10) @(posedge i_core_clk);
		wst(ST_RUN, 1);
		panel.current(16'h0101);
		wst(ST_WAIT, 10);
		rc(A_STATUS, 32'h7, 32'h7);
		results();
	end
endmodule
